// ===== verilog/pom_defines.svh
// constants of the remappable pin output multiplexer
// assumes a 32-bit APB slave port with word-aligned registers
`ifndef POM_DEFINES_SVH
`define POM_DEFINES_SVH
`define POM_NUM_PINS 47
`define POM_NUM_REGS 24
`define POM_SEL_W 4
`define POM_NUM_CODES 16
`define POM_MAP_W 8
`define POM_ADDR_W 12
`define POM_DATA_W 32
`define POM_MAP_BASE 12'h000
`define POM_MAP_LAST 12'h05C
`define POM_CTRL_OFF 12'h060
`define POM_STAT_OFF 12'h064
`define POM_LOCK_BIT 0
`define POM_REFUSED_BIT 0
`define POM_EVEN_LO 0
`define POM_ODD_LO 4
`define POM_MAP_RESET 8'h00
`define POM_WORD_RESET 32'h0000_0000
`define POM_SEL_NONE 4'h0
`define POM_VALID_G0 16'h6FFE
`define POM_VALID_G1 16'h67FE
`define POM_VALID_G2 16'h67FE
`define POM_VALID_G3 16'h63FE
`endif

// ===== verilog/pom_pkg.sv
// types shared by the pin output multiplexer files
// assumes pom_defines.svh sits on the include path
`include "pom_defines.svh"
package pom_pkg;
  typedef enum logic [1:0] {
    POM_GRP_4N0 = 2'b00,
    POM_GRP_4N1 = 2'b01,
    POM_GRP_4N2 = 2'b10,
    POM_GRP_4N3 = 2'b11
  } pom_group_t;
  typedef struct packed {
    logic lock;
    logic refused;
    logic rd_map;
    logic [`POM_DATA_W-1:0] prdata;
    logic [`POM_NUM_PINS-1:0] pin_out;
    logic [`POM_NUM_PINS-1:0] pin_drive;
  } pom_top_state_t;
endpackage

// ===== verilog/pom_map_regs.sv
// selector storage: one byte per pin pair, registered read port
// assumes write and read requests come from logic on the same clock
`timescale 1ns/10ps
`include "pom_defines.svh"
module pom_map_regs #(
  parameter int NREGS = `POM_NUM_REGS,
  parameter int W = `POM_MAP_W,
  parameter int IDX_W = 5
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  // read port
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [W-1:0] rd_data,
  // every selector at once, for the pin muxes
  output logic [NREGS-1:0][W-1:0] all_q
);
  typedef struct packed {
    logic [NREGS-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } pom_mem_state_t;
  pom_mem_state_t st_reg;
  pom_mem_state_t st_next;
  // the last pin stands alone, so its high nibble is unimplemented
  localparam logic [W-1:0] LAST_MASK = {{(W/2){1'b0}}, {(W/2){1'b1}}};

  always_comb begin
    st_next = st_reg;
    if (wr_en && (int'(wr_idx) < NREGS)) begin
      st_next.mem[wr_idx] = (int'(wr_idx) == NREGS - 1) ? (wr_data & LAST_MASK) : wr_data;
    end
    st_next.rd = (int'(rd_idx) < NREGS) ? st_reg.mem[rd_idx] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd;
  assign all_q = st_reg.mem;
endmodule // pom_map_regs

// ===== verilog/pom_group_mux.sv
// one pin's source selector within its group's choice list
// assumes src holds zero at unused, reserved and null codes
`timescale 1ns/10ps
`include "pom_defines.svh"
module pom_group_mux #(
  parameter pom_pkg::pom_group_t GROUP = pom_pkg::POM_GRP_4N0
) (
  // selector and the group's sources
  input wire logic [`POM_SEL_W-1:0] sel,
  input wire logic [`POM_NUM_CODES-1:0] src,
  // routed level and whether a source is connected
  output logic out,
  output logic mapped
);
  localparam logic [`POM_NUM_CODES-1:0] VALID =
    (GROUP == pom_pkg::POM_GRP_4N0) ? `POM_VALID_G0 :
    (GROUP == pom_pkg::POM_GRP_4N1) ? `POM_VALID_G1 :
    (GROUP == pom_pkg::POM_GRP_4N2) ? `POM_VALID_G2 : `POM_VALID_G3;

  assign mapped = VALID[sel];
  assign out = src[sel] & VALID[sel];
endmodule // pom_group_mux

// ===== verilog/pom_top.sv
// remappable pin output multiplexer with its APB register file
// assumes peripheral outputs are synchronous to pclk; pins driven from flops
//
// Operation
// - bits 7-4 select odd pin's source
// - bits 3-0 select even pin's source
// - map writes ignored while write lock set
// - selector routes at most one named source
// - group 4n code list
// - group 4n+1 code list
// - group 4n+2 list; last pin low nibble
// - group 4n+3 code list
// - map registers reset to zero
// - code zero connects nothing
// - sources reach only their group's pins
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`include "pom_defines.svh"
module pom_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`POM_ADDR_W-1:0] paddr,
  input wire logic [`POM_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [`POM_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // group 4n peripheral outputs
  input wire logic uart2_baud_clock_out,
  input wire logic uart3_rx_data_sync,
  input wire logic uart4_rx_data_sync,
  input wire logic spi2_data_out,
  input wire logic enhanced_pwm1_d,
  input wire logic enhanced_pwm2_d,
  input wire logic enhanced_pwm3_b,
  input wire logic charge_time_pulse,
  input wire logic capture_compare_5,
  input wire logic capture_compare_8,
  input wire logic comparator1_out,
  input wire logic virtual_remap_0,
  input wire logic virtual_remap_4,
  // group 4n+1 peripheral outputs
  input wire logic uart1_baud_clock_out,
  input wire logic uart3_tx_clock,
  input wire logic uart4_tx_clock,
  input wire logic spi1_data_out,
  input wire logic enhanced_pwm1_c,
  input wire logic enhanced_pwm2_c,
  input wire logic enhanced_pwm3_c,
  input wire logic capture_compare_7,
  input wire logic capture_compare_9,
  input wire logic comparator2_out,
  input wire logic virtual_remap_1,
  input wire logic virtual_remap_5,
  // group 4n+2 peripheral outputs
  input wire logic uart1_tx_clock,
  input wire logic uart2_rx_data_sync,
  input wire logic uart3_baud_clock_out,
  input wire logic uart4_baud_clock_out,
  input wire logic spi2_clock_out,
  input wire logic enhanced_pwm1_b,
  input wire logic enhanced_pwm2_b,
  input wire logic enhanced_pwm3_a,
  input wire logic capture_compare_6,
  input wire logic capture_compare_10,
  input wire logic virtual_remap_2,
  input wire logic virtual_remap_6,
  // group 4n+3 peripheral outputs
  input wire logic uart1_rx_data_sync,
  input wire logic uart2_tx_clock,
  input wire logic spi1_clock_out,
  input wire logic enhanced_pwm1_a,
  input wire logic enhanced_pwm2_a,
  input wire logic enhanced_pwm3_d,
  input wire logic modulator_out,
  input wire logic capture_compare_4,
  input wire logic comparator3_out,
  input wire logic virtual_remap_3,
  input wire logic virtual_remap_7,
  // remappable pins
  output logic [`POM_NUM_PINS-1:0] remappable_pin_out,
  output logic [`POM_NUM_PINS-1:0] remappable_pin_drive,
  // lock state for the rest of the chip
  output logic map_write_lock
);
  localparam int IDX_W = 5;

  pom_pkg::pom_top_state_t st_reg;
  pom_pkg::pom_top_state_t st_next;

  logic [`POM_NUM_CODES-1:0] src_g0;
  logic [`POM_NUM_CODES-1:0] src_g1;
  logic [`POM_NUM_CODES-1:0] src_g2;
  logic [`POM_NUM_CODES-1:0] src_g3;
  logic [`POM_NUM_REGS-1:0][`POM_MAP_W-1:0] map_q;
  logic [`POM_MAP_W-1:0] map_rd;
  logic [`POM_NUM_PINS-1:0] mux_out;
  logic [`POM_NUM_PINS-1:0] mux_mapped;

  logic setup_ph;
  logic access_ph;
  logic hit_map;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_none;
  logic map_wr_req;
  logic map_wr_en;
  logic refuse_evt;
  logic refuse_clr;
  logic [IDX_W-1:0] word_idx;

  // source lists, index is the selector code; null, unused and reserved
  // codes carry a constant zero so nothing leaks onto the pin
  assign src_g0 = {
    1'b0,                 // reserved
    virtual_remap_4,
    virtual_remap_0,
    1'b0,                 // unused
    comparator1_out,
    capture_compare_8,
    capture_compare_5,
    charge_time_pulse,
    enhanced_pwm3_b,
    enhanced_pwm2_d,
    enhanced_pwm1_d,
    spi2_data_out,
    uart4_rx_data_sync,
    uart3_rx_data_sync,
    uart2_baud_clock_out,
    1'b0                  // disconnected
  };
  assign src_g1 = {
    1'b0,                 // reserved
    virtual_remap_5,
    virtual_remap_1,
    1'b0,                 // unused
    1'b0,                 // unused
    comparator2_out,
    capture_compare_9,
    capture_compare_7,
    enhanced_pwm3_c,
    enhanced_pwm2_c,
    enhanced_pwm1_c,
    spi1_data_out,
    uart4_tx_clock,
    uart3_tx_clock,
    uart1_baud_clock_out,
    1'b0                  // disconnected
  };
  assign src_g2 = {
    1'b0,                 // reserved
    virtual_remap_6,
    virtual_remap_2,
    1'b0,                 // unused
    1'b0,                 // unused
    capture_compare_10,
    capture_compare_6,
    enhanced_pwm3_a,
    enhanced_pwm2_b,
    enhanced_pwm1_b,
    spi2_clock_out,
    uart4_baud_clock_out,
    uart3_baud_clock_out,
    uart2_rx_data_sync,
    uart1_tx_clock,
    1'b0                  // disconnected
  };
  assign src_g3 = {
    1'b0,                 // reserved
    virtual_remap_7,
    virtual_remap_3,
    1'b0,                 // unused
    1'b0,                 // unused
    1'b0,                 // unused
    comparator3_out,
    capture_compare_4,
    modulator_out,
    enhanced_pwm3_d,
    enhanced_pwm2_a,
    enhanced_pwm1_a,
    spi1_clock_out,
    uart2_tx_clock,
    uart1_rx_data_sync,
    1'b0                  // disconnected
  };

  // apb phase and address decode
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign word_idx = paddr[IDX_W+1:2];

  always_comb begin
    hit_map = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_none = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      hit_none = 1'b1;
    end else if (paddr <= `POM_MAP_LAST) begin
      hit_map = 1'b1;
    end else if (paddr == `POM_CTRL_OFF) begin
      hit_ctrl = 1'b1;
    end else if (paddr == `POM_STAT_OFF) begin
      hit_stat = 1'b1;
    end else begin
      hit_none = 1'b1;
    end
  end

  // a locked map write completes on the bus, leaves the map unchanged and sets the refused flag
  assign map_wr_req = access_ph && pwrite && hit_map && pstrb[0];
  assign map_wr_en = map_wr_req && !st_reg.lock;
  assign refuse_evt = map_wr_req && st_reg.lock;
  assign refuse_clr = access_ph && pwrite && hit_stat && pstrb[0] &&
    pwdata[`POM_REFUSED_BIT];

  // register k holds pins 2k (low nibble) and 2k+1 (high nibble)
  pom_map_regs #(
    .NREGS(`POM_NUM_REGS),
    .W(`POM_MAP_W),
    .IDX_W(IDX_W)
  ) u_map_regs (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(map_wr_en),
    .wr_idx(word_idx),
    .wr_data(pwdata[`POM_MAP_W-1:0]),
    .rd_idx(word_idx),
    .rd_data(map_rd),
    .all_q(map_q)
  );

  // one mux per pin, fed only by the list of the pin's own group
  for (genvar p = 0; p < `POM_NUM_PINS; p++) begin : g_pin
    localparam pom_pkg::pom_group_t GRP = pom_pkg::pom_group_t'(p % 4);
    localparam int NIB = (p % 2 == 1) ? `POM_ODD_LO : `POM_EVEN_LO;
    logic [`POM_NUM_CODES-1:0] src;
    logic [`POM_SEL_W-1:0] sel;
    assign src = (GRP == pom_pkg::POM_GRP_4N0) ? src_g0 :
      (GRP == pom_pkg::POM_GRP_4N1) ? src_g1 :
      (GRP == pom_pkg::POM_GRP_4N2) ? src_g2 : src_g3;
    assign sel = map_q[p/2][NIB +: `POM_SEL_W];
    pom_group_mux #(
      .GROUP(GRP)
    ) u_mux (
      .sel(sel),
      .src(src),
      .out(mux_out[p]),
      .mapped(mux_mapped[p])
    );
  end

  always_comb begin
    st_next = st_reg;
    // control register: lock bit
    if (access_ph && pwrite && hit_ctrl && pstrb[0]) begin
      st_next.lock = pwdata[`POM_LOCK_BIT];
    end
    // refused-write flag: a new refusal beats a clear in the same cycle
    st_next.refused = (st_reg.refused && !refuse_clr) || refuse_evt;
    // read data is prepared in the setup cycle so prdata comes from flops
    if (setup_ph) begin
      st_next.rd_map = hit_map;
      st_next.prdata = `POM_WORD_RESET;
      if (hit_ctrl) begin
        st_next.prdata[`POM_LOCK_BIT] = st_reg.lock;
      end else if (hit_stat) begin
        st_next.prdata[`POM_REFUSED_BIT] = st_reg.refused;
      end
    end
    // pins follow the selectors one clock later
    st_next.pin_out = mux_out;
    st_next.pin_drive = mux_mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // zero wait states; bad addresses answer with an error and read zero
  assign pready = 1'b1;
  assign pslverr = access_ph && hit_none;
  assign prdata = st_reg.rd_map ? {{(`POM_DATA_W-`POM_MAP_W){1'b0}}, map_rd} : st_reg.prdata;
  assign remappable_pin_out = st_reg.pin_out;
  assign remappable_pin_drive = st_reg.pin_drive;
  assign map_write_lock = st_reg.lock;
endmodule // pom_top

// ===== dv/pom_top_monitor.sv
// checker for the pin output multiplexer: lock, reset and pin drive relations
// assumes it is bound to pom_top; a map write shows on the pins within two cycles
`timescale 1ns/10ps
`include "pom_defines.svh"
module pom_top_monitor (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`POM_ADDR_W-1:0] paddr,
  input wire logic [`POM_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // pins and lock
  input wire logic [`POM_NUM_PINS-1:0] remappable_pin_out,
  input wire logic [`POM_NUM_PINS-1:0] remappable_pin_drive,
  input wire logic map_write_lock
);
  logic wr_q;
  logic [4:0] k_q;
  logic [7:0] d_q;
  wire logic acc = psel && penable && pwrite && pstrb[0];
  function automatic logic ok(input logic [1:0] g, input logic [3:0] c);
    return c != 4'h0 && c != 4'hF && (c > 4'hC || c <= (g == 2'h0 ? 4'hB : g == 2'h3 ? 4'h9 : 4'hA));
  endfunction
  // capture only on an access, so the next write cannot disturb the pending check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 1'b0;
      k_q <= 5'h00;
      d_q <= 8'h00;
    end else begin
      wr_q <= acc && !map_write_lock && paddr <= 12'h05C && paddr[1:0] == 2'h0;
      if (acc) begin
        k_q <= paddr[6:2];
        d_q <= pwdata[7:0];
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  even_pin_select_a: assert property (wr_q |=>
    remappable_pin_drive[{k_q, 1'b0}] == ok({k_q[0], 1'b0}, d_q[3:0])) else $error("even pin drive");
  odd_pin_select_a: assert property (wr_q && k_q != 5'h17 |=>
    remappable_pin_drive[{k_q, 1'b1}] == ok({k_q[0], 1'b1}, d_q[7:4])) else $error("odd pin drive");
  locked_write_ignored_a: assert property (acc && map_write_lock && paddr <= 12'h05C |->
    ##2 remappable_pin_drive == $past(remappable_pin_drive, 2)) else $error("locked write took");
  lock_follows_write_a: assert property (acc && paddr == 12'h060 |=>
    map_write_lock == $past(pwdata[0])) else $error("lock bit");
  reset_pins_idle_a: assert property ($rose(presetn) |->
    remappable_pin_drive == '0 && remappable_pin_out == '0) else $error("pins after reset");
  undriven_pin_low_a: assert property (
    (remappable_pin_out & ~remappable_pin_drive) == '0) else $error("pin without source");
  zero_wait_a: assert property (psel && penable |-> pready) else $error("wait state");
  unmapped_error_a: assert property (psel && penable && paddr > 12'h064 |-> pslverr)
    else $error("no error response");
endmodule // pom_top_monitor

// ===== dv/pom_periph_model.sv
// peripheral output model: one code raised per group, or all but that one
// assumes peripheral outputs change on pclk like the real ones
`timescale 1ns/10ps
module pom_periph_model (
  // clock
  input wire logic pclk,
  // chosen code for even and odd pin groups, and inversion
  input wire logic [3:0] code_even,
  input wire logic [3:0] code_odd,
  input wire logic invert,
  // sources by group and code
  output logic [3:0][15:0] src
);
  always_ff @(posedge pclk) begin
    for (int g = 0; g < 4; g++) begin
      for (int c = 0; c < 16; c++) begin
        src[g][c] <= (c == int'(g[0] ? code_odd : code_even)) ^ invert;
      end
    end
  end
endmodule // pom_periph_model

// ===== dv/test_pin_output_remap.sv
// bench for the pin output multiplexer: apb tasks, code sweep, lock and reset
// assumes pom_top and the peripheral model; pstrb is held at all lanes
`timescale 1ns/10ps
`include "pom_defines.svh"
module test_pin_output_remap;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, map_write_lock, err;
  logic [46:0] remappable_pin_out, remappable_pin_drive;
  logic [3:0] ce = 4'h0;
  logic [3:0] co = 4'h0;
  logic inv = 1'b0;
  logic [3:0][15:0] s;
  logic [31:0] rd;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  pom_periph_model u_src (.pclk(pclk), .code_even(ce), .code_odd(co), .invert(inv), .src(s));
  pom_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .map_write_lock(map_write_lock),
    .remappable_pin_out(remappable_pin_out), .remappable_pin_drive(remappable_pin_drive),
    .uart2_baud_clock_out(s[0][1]), .uart3_rx_data_sync(s[0][2]), .uart4_rx_data_sync(s[0][3]),
    .spi2_data_out(s[0][4]), .enhanced_pwm1_d(s[0][5]), .enhanced_pwm2_d(s[0][6]),
    .enhanced_pwm3_b(s[0][7]), .charge_time_pulse(s[0][8]), .capture_compare_5(s[0][9]),
    .capture_compare_8(s[0][10]), .comparator1_out(s[0][11]), .virtual_remap_0(s[0][13]),
    .virtual_remap_4(s[0][14]), .uart1_baud_clock_out(s[1][1]), .uart3_tx_clock(s[1][2]),
    .uart4_tx_clock(s[1][3]), .spi1_data_out(s[1][4]), .enhanced_pwm1_c(s[1][5]),
    .enhanced_pwm2_c(s[1][6]), .enhanced_pwm3_c(s[1][7]), .capture_compare_7(s[1][8]),
    .capture_compare_9(s[1][9]), .comparator2_out(s[1][10]), .virtual_remap_1(s[1][13]),
    .virtual_remap_5(s[1][14]), .uart1_tx_clock(s[2][1]), .uart2_rx_data_sync(s[2][2]),
    .uart3_baud_clock_out(s[2][3]), .uart4_baud_clock_out(s[2][4]), .spi2_clock_out(s[2][5]),
    .enhanced_pwm1_b(s[2][6]), .enhanced_pwm2_b(s[2][7]), .enhanced_pwm3_a(s[2][8]),
    .capture_compare_6(s[2][9]), .capture_compare_10(s[2][10]), .virtual_remap_2(s[2][13]),
    .virtual_remap_6(s[2][14]), .uart1_rx_data_sync(s[3][1]), .uart2_tx_clock(s[3][2]),
    .spi1_clock_out(s[3][3]), .enhanced_pwm1_a(s[3][4]), .enhanced_pwm2_a(s[3][5]),
    .enhanced_pwm3_d(s[3][6]), .modulator_out(s[3][7]), .capture_compare_4(s[3][8]),
    .comparator3_out(s[3][9]), .virtual_remap_3(s[3][13]), .virtual_remap_7(s[3][14]));
  always #4 pclk = ~pclk;
  // the sweep needs about 5400 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic ok(input int p, input logic [3:0] c);
    return c != 4'h0 && c != 4'hF && (c > 4'hC || c <= (p % 4 == 0 ? 4'hB : p % 4 == 3 ? 4'h9 : 4'hA));
  endfunction
  task pin(input int p, input logic [3:0] c);
    chk(remappable_pin_drive[p], ok(p, c));
    chk(remappable_pin_out[p], inv ? 1'b0 : ok(p, c));
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 24; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      chk(rd, 64'h0);
    end
    chk(remappable_pin_drive, 64'h0);
    for (int k = 0; k < 24; k++) begin
      for (int c = 0; c < 16; c++) begin
        apb(1'b1, 12'(4 * k), 32'(16 * (15 - c) + c));
        apb(1'b0, 12'(4 * k), 32'h0);
        chk(rd, k == 23 ? 64'(c) : 64'(16 * (15 - c) + c));
        for (int i = 0; i < 2; i++) begin
          @(posedge pclk);
          ce <= 4'(c);
          co <= 4'(15 - c);
          inv <= i[0];
          repeat (3) @(posedge pclk);
          pin(2 * k, 4'(c));
          if (k < 23) pin(2 * k + 1, 4'(15 - c));
        end
      end
    end
    apb(1'b1, 12'h060, 32'h1);
    @(posedge pclk);
    chk(map_write_lock, 64'h1);
    apb(1'b1, 12'h000, 32'h55);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 64'h0F);
    apb(1'b0, 12'h064, 32'h0);
    chk(rd, 64'h1);
    apb(1'b0, 12'h060, 32'h0);
    chk(rd, 64'h1);
    apb(1'b1, 12'h064, 32'h1);
    apb(1'b0, 12'h064, 32'h0);
    chk(rd, 64'h0);
    apb(1'b1, 12'h060, 32'h0);
    apb(1'b1, 12'h000, 32'h55);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 64'h55);
    apb(1'b0, 12'h064, 32'h0);
    chk(rd, 64'h0);
    apb(1'b1, 12'h060, 32'h1);
    apb(1'b0, 12'h068, 32'h0);
    chk({err, rd}, 64'h1_0000_0000);
    apb(1'b0, 12'h002, 32'h0);
    chk({err, rd}, 64'h1_0000_0000);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    chk(map_write_lock, 64'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 64'h0);
    test_done();
  end
endmodule // test_pin_output_remap
bind pom_top pom_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .remappable_pin_out(remappable_pin_out),
  .remappable_pin_drive(remappable_pin_drive), .map_write_lock(map_write_lock));
